// ==== hw/dst_pkg.sv ====
/*
  Constants shared by the disk controller self-test block: register addresses,
  status count milestones, patterns and timing.
  Assumes a 40 MHz controller clock and 16-bit host data.
*/
package dst_pkg;

  // ==========================================================================
  // Register map
  localparam logic [15:0] ADDR_STATUS_COUNT = 16'hF804;
  localparam logic [15:0] ADDR_STATUS_WORD = 16'hF80E;
  localparam int BUSY_BIT = 15;

  // ==========================================================================
  // Status count milestones and patterns
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_PRE_SHORT = 16'h0010;
  localparam logic [15:0] COUNT_PRE_LONG = 16'h0013;
  localparam logic [15:0] COUNT_STEP = 16'h0001;
  localparam logic [15:0] LONG_PASS_VALUE = 16'hFF00;
  localparam logic [7:0] ERROR_LEFT_BYTE = 8'hFF;
  localparam logic [7:0] ERROR_FLAG_BYTE = 8'hFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] PATTERN_ONES = 16'hFFFF;
  localparam logic [15:0] PATTERN_ZEROS = 16'h0000;
  localparam logic [15:0] READ_ZERO = 16'h0000;

  // ==========================================================================
  // Timing
  localparam int CLK_HZ = 40_000_000;
  localparam int CMD_TIMER_MS = 100;
  localparam int DELAY_LOOP_MS = 150;
  localparam int CMD_TIMER_CYCLES = CMD_TIMER_MS * (CLK_HZ / 1000);
  localparam int DELAY_LOOP_CYCLES = DELAY_LOOP_MS * (CLK_HZ / 1000);
  localparam int CLOCK_LED_DIV_BITS = 4;

  typedef enum {
    DST_IDLE,
    DST_PRIOR,
    DST_DR_ONES,
    DST_DR_ONES_CHK,
    DST_RDY_CLR,
    DST_RDY_CLR_CHK,
    DST_DR_ZEROS,
    DST_DR_ZEROS_CHK,
    DST_RDY_RST,
    DST_RDY_RST_CHK,
    DST_TMR_LOOP,
    DST_TERMINATE,
    DST_ERROR
  } dst_state_t;

endpackage : dst_pkg

// ==== hw/dst_if.sv ====
/*
  Carrier between the self-test sequencer and the tested unit holding the
  direct register, the ready-direct latch and the command timer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
interface dst_if;
  logic dr_load;
  logic [15:0] dr_wdata;
  logic [15:0] dr_q;
  logic rdy_reset;
  logic rdy_flag;
  logic tmr_run;
  logic tmr_expire;

  modport seq (
    output dr_load,
    output dr_wdata,
    input dr_q,
    output rdy_reset,
    input rdy_flag,
    output tmr_run,
    input tmr_expire
  );

  modport unit (
    input dr_load,
    input dr_wdata,
    output dr_q,
    input rdy_reset,
    output rdy_flag,
    input tmr_run,
    output tmr_expire
  );
endinterface : dst_if

// ==== hw/dst_unit.sv ====
/*
  Direct register, ready-direct latch and command timer under test.
  Assumes the sequencer drives the seq modport on the same clock.
*/
`timescale 1ns/100ps
module dst_unit
  import dst_pkg::*;
#(
  parameter int TIMER_CYCLES = CMD_TIMER_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Sequencer side
  dst_if.unit bus
);

  logic [15:0] dr_d, dr_q;
  logic rdy_d, rdy_q;
  logic [31:0] tmr_d, tmr_q;
  logic expire;

  // ==========================================================================
  // Next state
  always_comb begin
    dr_d = dr_q;
    rdy_d = rdy_q;
    expire = 1'b0;
    if (bus.dr_load) begin
      dr_d = bus.dr_wdata;
    end
    // A load sets the latch; a set in the same cycle as a reset wins.
    if (bus.dr_load) begin
      rdy_d = 1'b1;
    end else if (bus.rdy_reset) begin
      rdy_d = 1'b0;
    end
    tmr_d = 32'h0000_0000;
    if (bus.tmr_run) begin
      if (tmr_q == 32'(TIMER_CYCLES - 1)) begin
        expire = 1'b1;
      end else begin
        tmr_d = tmr_q + 32'h0000_0001;
      end
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      dr_q <= PATTERN_ZEROS;
      rdy_q <= 1'b0;
      tmr_q <= 32'h0000_0000;
    end else begin
      dr_q <= dr_d;
      rdy_q <= rdy_d;
      tmr_q <= tmr_d;
    end
  end

  assign bus.dr_q = dr_q;
  assign bus.rdy_flag = rdy_q;
  assign bus.tmr_expire = expire;

endmodule : dst_unit

// ==== hw/dst_top.sv ====
/*
  Self-test sequencer and indicator logic of the cartridge disk controller.
  Assumes earlier test segments are run elsewhere and report pass or fail pulses,
  and that the host reads registers with a one-cycle read strobe.
*/
`timescale 1ns/100ps
module dst_top
  import dst_pkg::*;
#(
  parameter int TIMER_CYCLES = CMD_TIMER_CYCLES,
  parameter int DELAY_CYCLES = DELAY_LOOP_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Host commands
  input wire logic io_reset_req,
  input wire logic cmd_start,
  input wire logic long_option_fitted,
  input wire logic int_clear,
  input wire logic timer_int_enable,
  // Earlier segments
  input wire logic seg_pass,
  input wire logic seg_fail,
  // Register read port
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  output logic [15:0] reg_rdata,
  output logic reg_ack,
  // Observation lines
  output logic [15:0] disk_addr_lines,
  output logic spare_sync_toggle_line,
  // Indicators
  output logic busy_led,
  output logic interrupt_led,
  output logic fault_led,
  output logic clock_led
);

  dst_if link ();

  dst_unit #(
    .TIMER_CYCLES(TIMER_CYCLES)
  ) u_unit (
    .clock(clock),
    .reset(reset),
    .bus(link.unit)
  );

  // ==========================================================================
  // State
  dst_state_t state_d, state_q;
  logic long_d, long_q;
  logic [15:0] count_d, count_q;
  logic [15:0] status_count_d, status_count_q;
  logic [7:0] flag_byte_d, flag_byte_q;
  logic [15:0] acc_d, acc_q;
  logic test_mode_d, test_mode_q;
  logic [31:0] delay_d, delay_q;
  logic fault_d, fault_q;
  logic int_d, int_q;
  logic spare_d, spare_q;
  logic [15:0] disk_addr_d, disk_addr_q;
  logic count_update;
  logic [15:0] pre_count;

  // ==========================================================================
  // Sequencer
  always_comb begin
    state_d = state_q;
    long_d = long_q;
    count_d = count_q;
    status_count_d = status_count_q;
    flag_byte_d = flag_byte_q;
    acc_d = acc_q;
    test_mode_d = test_mode_q;
    delay_d = delay_q;
    fault_d = fault_q;
    int_d = int_q;
    count_update = 1'b0;
    link.dr_load = 1'b0;
    link.dr_wdata = PATTERN_ZEROS;
    link.rdy_reset = 1'b0;
    link.tmr_run = 1'b0;
    pre_count = long_q ? COUNT_PRE_LONG : COUNT_PRE_SHORT;
    case (state_q)
      DST_IDLE: begin
        if ((io_reset_req && long_option_fitted) || cmd_start) begin
          long_d = io_reset_req && long_option_fitted;
          count_d = COUNT_RESET;
          fault_d = 1'b1;
          state_d = DST_PRIOR;
        end
      end
      DST_PRIOR: begin
        if (seg_fail) begin
          state_d = DST_ERROR;
        end else if (seg_pass) begin
          count_update = 1'b1;
          if (count_q + COUNT_STEP == pre_count) begin
            state_d = DST_DR_ONES;
          end
        end
      end
      DST_DR_ONES: begin
        link.dr_load = 1'b1;
        link.dr_wdata = PATTERN_ONES;
        acc_d = PATTERN_ONES;
        state_d = DST_DR_ONES_CHK;
      end
      DST_DR_ONES_CHK: begin
        if (link.dr_q == acc_q && link.rdy_flag) begin
          count_update = 1'b1;
          state_d = DST_RDY_CLR;
        end else begin
          state_d = DST_ERROR;
        end
      end
      DST_RDY_CLR: begin
        link.rdy_reset = 1'b1;
        state_d = DST_RDY_CLR_CHK;
      end
      DST_RDY_CLR_CHK: begin
        if (!link.rdy_flag) begin
          count_update = 1'b1;
          // Short test stops here and lets the command run.
          state_d = long_q ? DST_DR_ZEROS : DST_TERMINATE;
        end else begin
          state_d = DST_ERROR;
        end
      end
      DST_DR_ZEROS: begin
        link.dr_load = 1'b1;
        link.dr_wdata = PATTERN_ZEROS;
        acc_d = PATTERN_ZEROS;
        state_d = DST_DR_ZEROS_CHK;
      end
      DST_DR_ZEROS_CHK: begin
        state_d = (link.dr_q == acc_q) ? DST_RDY_RST : DST_ERROR;
      end
      DST_RDY_RST: begin
        link.rdy_reset = 1'b1;
        state_d = DST_RDY_RST_CHK;
      end
      DST_RDY_RST_CHK: begin
        if (!link.rdy_flag) begin
          test_mode_d = 1'b1;
          delay_d = 32'h0000_0000;
          state_d = DST_TMR_LOOP;
        end else begin
          state_d = DST_ERROR;
        end
      end
      DST_TMR_LOOP: begin
        link.tmr_run = 1'b1;
        // The interrupt routine only acts while test mode is up.
        if (link.tmr_expire && timer_int_enable && test_mode_q) begin
          test_mode_d = 1'b0;
        end
        if (delay_q == 32'(DELAY_CYCLES - 1)) begin
          state_d = test_mode_d ? DST_ERROR : DST_TERMINATE;
        end else begin
          delay_d = delay_q + 32'h0000_0001;
        end
      end
      DST_TERMINATE: begin
        fault_d = 1'b0;
        if (long_q) begin
          status_count_d = LONG_PASS_VALUE;
        end
        int_d = 1'b1;
        state_d = DST_IDLE;
      end
      DST_ERROR: begin
        // Fault stays lit so a failed test is visible on the board.
        if (long_q) begin
          status_count_d = {ERROR_LEFT_BYTE, count_q[7:0]};
        end else begin
          status_count_d = count_q;
        end
        flag_byte_d = ERROR_FLAG_BYTE;
        test_mode_d = 1'b0;
        int_d = 1'b1;
        state_d = DST_IDLE;
      end
      default: begin
        state_d = DST_IDLE;
      end
    endcase
    if (count_update) begin
      count_d = count_q + COUNT_STEP;
    end
    if (link.tmr_expire) begin
      fault_d = 1'b1;
    end
    // Clearing and raising in one cycle keeps the new interrupt.
    if (int_clear && !(state_q == DST_TERMINATE || state_q == DST_ERROR)) begin
      int_d = 1'b0;
    end
  end

  // ==========================================================================
  // Observation lines
  always_comb begin
    spare_d = spare_q;
    disk_addr_d = disk_addr_q;
    if (count_update) begin
      spare_d = ~spare_q;
      disk_addr_d = count_q + COUNT_STEP;
    end else if (state_q == DST_TERMINATE || state_q == DST_ERROR) begin
      disk_addr_d = status_count_d;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q <= DST_IDLE;
      long_q <= 1'b0;
      count_q <= COUNT_RESET;
      status_count_q <= COUNT_RESET;
      flag_byte_q <= BYTE_ZERO;
      acc_q <= PATTERN_ZEROS;
      test_mode_q <= 1'b0;
      delay_q <= 32'h0000_0000;
      fault_q <= 1'b0;
      int_q <= 1'b0;
      spare_q <= 1'b0;
      disk_addr_q <= COUNT_RESET;
    end else begin
      state_q <= state_d;
      long_q <= long_d;
      count_q <= count_d;
      status_count_q <= status_count_d;
      flag_byte_q <= flag_byte_d;
      acc_q <= acc_d;
      test_mode_q <= test_mode_d;
      delay_q <= delay_d;
      fault_q <= fault_d;
      int_q <= int_d;
      spare_q <= spare_d;
      disk_addr_q <= disk_addr_d;
    end
  end

  // ==========================================================================
  // Register read port
  logic [15:0] rdata_d, rdata_q;
  logic ack_d, ack_q;
  logic [15:0] status_word;

  always_comb begin
    status_word = {BYTE_ZERO, flag_byte_q};
    status_word[BUSY_BIT] = state_q != DST_IDLE;
    ack_d = reg_rd;
    rdata_d = READ_ZERO;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_STATUS_COUNT: rdata_d = status_count_q;
        ADDR_STATUS_WORD: rdata_d = status_word;
        default: rdata_d = READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rdata_q <= READ_ZERO;
      ack_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      ack_q <= ack_d;
    end
  end

  // ==========================================================================
  // Clock indicator
  // A divided toggle keeps the lamp dim while running; a stopped clock freezes it.
  logic [CLOCK_LED_DIV_BITS-1:0] div_d, div_q;

  always_comb begin
    div_d = div_q + {{(CLOCK_LED_DIV_BITS-1){1'b0}}, 1'b1};
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end

  // ==========================================================================
  // Outputs
  assign reg_rdata = rdata_q;
  assign reg_ack = ack_q;
  assign disk_addr_lines = disk_addr_q;
  assign spare_sync_toggle_line = spare_q;
  assign busy_led = state_q != DST_IDLE;
  assign interrupt_led = int_q;
  assign fault_led = fault_q;
  assign clock_led = div_q[CLOCK_LED_DIV_BITS-1];

endmodule : dst_top

// ==== test/dst_top_sva.sv ====
/*
  Assertion checker for the self-test block, bound to its top module.
  Assumes one clock domain and a host read strobe one cycle long.
*/
`timescale 1ns/100ps
module dst_top_sva
  import dst_pkg::*;
#(
  parameter int TIMER_CYCLES = CMD_TIMER_CYCLES,
  parameter int DELAY_CYCLES = DELAY_LOOP_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Host side
  input wire logic int_clear,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_ack,
  // Observation and indicators
  input wire logic [15:0] disk_addr_lines,
  input wire logic spare_sync_toggle_line,
  input wire logic busy_led,
  input wire logic interrupt_led,
  input wire logic fault_led,
  input wire logic clock_led
);
  // ==========================================================================
  // Sequences
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_word_read;
    reg_rd && reg_addr == ADDR_STATUS_WORD;
  endsequence
  sequence s_unmapped_read;
    reg_rd && reg_addr != ADDR_STATUS_WORD && reg_addr != ADDR_STATUS_COUNT;
  endsequence
  sequence s_led_high;
    clock_led [*8] ##1 !clock_led;
  endsequence

  // ==========================================================================
  // Assertions
  ack_follows_read_a: assert property (reg_rd |=> reg_ack)
    else $error("read not answered in the next cycle");
  unmapped_zero_a: assert property (s_unmapped_read |=> reg_rdata == READ_ZERO)
    else $error("unmapped read gave nonzero data");
  busy_bit_a: assert property (s_word_read |=> reg_rdata[BUSY_BIT] == $past(busy_led))
    else $error("status word busy bit differs from busy indicator");
  spare_mirror_a: assert property ($changed(spare_sync_toggle_line) |-> $changed(disk_addr_lines))
    else $error("spare line toggled without a new count on the address lines");
  end_interrupt_a: assert property ($fell(busy_led) |-> interrupt_led)
    else $error("command ended without interrupt");
  interrupt_hold_a: assert property (interrupt_led && !int_clear |=> interrupt_led)
    else $error("interrupt indicator dropped without clear");
  fault_busy_a: assert property (busy_led && $past(busy_led) |-> fault_led)
    else $error("fault indicator dark during diagnostic");
  fault_start_a: assert property ($rose(busy_led) |-> fault_led)
    else $error("fault indicator not lit at diagnostic start");
  fault_end_a: assert property ($fell(fault_led) |-> $fell(busy_led))
    else $error("fault indicator cleared outside terminate");
  clock_period_a: assert property ($rose(clock_led) |-> s_led_high)
    else $error("clock indicator not a divided square wave");
endmodule : dst_top_sva

bind dst_top dst_top_sva #(.TIMER_CYCLES(TIMER_CYCLES), .DELAY_CYCLES(DELAY_CYCLES)) u_sva (
  .clock(clock), .reset(reset), .int_clear(int_clear), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
  .disk_addr_lines(disk_addr_lines), .spare_sync_toggle_line(spare_sync_toggle_line),
  .busy_led(busy_led), .interrupt_led(interrupt_led), .fault_led(fault_led),
  .clock_led(clock_led)
);

// ==== test/dst_host_model.sv ====
/*
  Host model that issues single register reads and returns the answer.
  Assumes requests from the bench are one-cycle pulses on go.
*/
`timescale 1ns/100ps
module dst_host_model (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Bench requests
  input wire logic go,
  input wire logic [15:0] go_addr,
  output logic [15:0] rd_data,
  output logic rd_done,
  // Register read port
  output logic reg_rd,
  output logic [15:0] reg_addr,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_ack
);
  // The address is inverted on every idle cycle, so a stale value shows again only on alternate idle cycles.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      reg_rd <= 1'b0;
      reg_addr <= 16'h0000;
      rd_data <= 16'h0000;
      rd_done <= 1'b0;
    end else begin
      rd_done <= reg_ack;
      if (reg_ack) begin
        rd_data <= reg_rdata;
      end
      reg_rd <= go;
      reg_addr <= go ? go_addr : ~reg_addr;
    end
  end
endmodule : dst_host_model

// ==== test/testbench.sv ====
/*
  Self-checking bench for the self-test block with shortened timer counts.
  Assumes the host model answers reads and the bench drives all other inputs.
*/
`timescale 1ns/100ps
module testbench;
  import dst_pkg::*;
  logic clock, reset, io_reset_req, cmd_start, long_option_fitted, int_clear;
  logic timer_int_enable, seg_pass, seg_fail, go, reg_rd, reg_ack, rd_done, spare, sp_seen;
  logic busy_led, interrupt_led, fault_led, clock_led;
  logic [15:0] go_addr, reg_addr, reg_rdata, rd_data, disk_addr_lines, last_disk;
  logic [31:0] seed;
  int err_count, compares, toggles;

  dst_top #(.TIMER_CYCLES(20), .DELAY_CYCLES(40)) dut (
    .clock(clock), .reset(reset), .io_reset_req(io_reset_req), .cmd_start(cmd_start),
    .long_option_fitted(long_option_fitted), .int_clear(int_clear),
    .timer_int_enable(timer_int_enable), .seg_pass(seg_pass), .seg_fail(seg_fail),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .disk_addr_lines(disk_addr_lines), .spare_sync_toggle_line(spare), .busy_led(busy_led),
    .interrupt_led(interrupt_led), .fault_led(fault_led), .clock_led(clock_led));
  dst_host_model host (
    .clock(clock), .reset(reset), .go(go), .go_addr(go_addr), .rd_data(rd_data),
    .rd_done(rd_done), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .reg_ack(reg_ack));

  // ==========================================================================
  // Helpers
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // Sampled at the falling edge so updates of the rising edge have landed.
  always @(negedge clock) begin
    if (spare !== sp_seen) begin
      toggles++;
      last_disk = disk_addr_lines;
    end
    sp_seen = spare;
  end
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift
  function automatic logic [15:0] pre_count(input logic lng);
    return lng ? COUNT_PRE_LONG : COUNT_PRE_SHORT;
  endfunction : pre_count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic do_reset;
    @(posedge clock);
    reset <= 1'b1;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
  endtask : do_reset
  task automatic read_reg(input logic [15:0] a, output logic [15:0] d);
    int i;
    @(posedge clock);
    go <= 1'b1;
    go_addr <= a;
    @(posedge clock);
    go <= 1'b0;
    i = 0;
    do begin
      @(negedge clock);
      i++;
    end while (rd_done !== 1'b1 && i < 10);
    if (rd_done !== 1'b1) begin
      err_count++;
      tally_and_finish();
    end
    d = rd_data;
  endtask : read_reg
  task automatic start_test(input logic lng, input int n);
    int i;
    @(posedge clock);
    toggles = 0;
    long_option_fitted <= lng;
    io_reset_req <= lng;
    cmd_start <= !lng;
    @(posedge clock);
    io_reset_req <= 1'b0;
    cmd_start <= 1'b0;
    for (i = 0; i < n; i++) begin
      seed = xorshift(seed);
      repeat (seed[1:0]) @(posedge clock);
      @(posedge clock);
      seg_pass <= 1'b1;
      @(posedge clock);
      seg_pass <= 1'b0;
    end
    @(negedge clock);
    check({15'h0, busy_led}, 16'h0001);
  endtask : start_test
  task automatic end_checks(input logic [15:0] cnt, input logic [7:0] flag, input logic flt,
                            input int tg);
    int i;
    logic [15:0] d;
    d = 16'hFFFF;
    for (i = 0; i < 100 && d[BUSY_BIT] !== 1'b0; i++) begin
      read_reg(ADDR_STATUS_WORD, d);
    end
    check({8'h00, d[7:0]}, {8'h00, flag});
    if (d[BUSY_BIT] !== 1'b0) begin
      err_count++;
      tally_and_finish();
    end
    check({15'h0, interrupt_led}, 16'h0001);
    check({15'h0, fault_led}, {15'h0, flt});
    check(toggles[15:0], tg[15:0]);
    if (tg > 0) check(last_disk, tg[15:0]);
    if (flag == ERROR_FLAG_BYTE) check(disk_addr_lines, cnt);
    read_reg(ADDR_STATUS_COUNT, d);
    check(d, cnt);
    @(posedge clock);
    int_clear <= 1'b1;
    @(posedge clock);
    int_clear <= 1'b0;
    @(negedge clock);
    check({15'h0, interrupt_led}, 16'h0000);
  endtask : end_checks

  // ==========================================================================
  // Scenarios
  initial begin
    logic [15:0] d;
    logic lng;
    int k, t;
    {reset, io_reset_req, cmd_start, long_option_fitted, int_clear} = 5'h10;
    {timer_int_enable, seg_pass, seg_fail, go, sp_seen} = 5'h00;
    go_addr = 16'h0000;
    seed = 32'h562162EE;
    {err_count, compares, toggles} = 0;
    do_reset();
    read_reg(ADDR_STATUS_COUNT, d);
    check(d, COUNT_RESET);
    seed = xorshift(seed);
    read_reg({seed[15:5], 5'h11}, d);
    check(d, READ_ZERO);
    @(posedge clock);
    io_reset_req <= 1'b1;
    @(posedge clock);
    io_reset_req <= 1'b0;
    repeat (3) @(posedge clock);
    @(negedge clock);
    check({15'h0, busy_led}, 16'h0000);
    $display("Test idle done");
    // The short test must pass with the timer disabled, as it skips that step.
    start_test(1'b0, COUNT_PRE_SHORT);
    end_checks(COUNT_RESET, BYTE_ZERO, 1'b0, COUNT_PRE_SHORT + 2);
    $display("Test short pass done");
    start_test(1'b1, COUNT_PRE_LONG);
    end_checks({ERROR_LEFT_BYTE, 8'h15}, ERROR_FLAG_BYTE, 1'b1, 8'h15);
    do_reset();
    $display("Test timer fail done");
    timer_int_enable <= 1'b1;
    start_test(1'b1, COUNT_PRE_LONG);
    end_checks(LONG_PASS_VALUE, BYTE_ZERO, 1'b0, 8'h15);
    $display("Test long pass done");
    for (t = 0; t < 4; t++) begin
      seed = xorshift(seed);
      lng = (t == 1) ? 1'b1 : seed[0];
      k = (t == 0) ? pre_count(lng) - 1 : (t == 1) ? 0 : seed[15:8] % pre_count(lng);
      start_test(lng, k);
      @(posedge clock);
      seg_fail <= 1'b1;
      @(posedge clock);
      seg_fail <= 1'b0;
      d = lng ? {ERROR_LEFT_BYTE, k[7:0]} : k[15:0];
      end_checks(d, ERROR_FLAG_BYTE, 1'b1, k);
      do_reset();
      $display("Test segment fail %0d done", t);
    end
    tally_and_finish();
  end
endmodule : testbench
